/* File: src/vlc_pkg.sv */
// vlc_pkg: shared constants and types for the vector loop sequencer
// assumes nothing beyond a SystemVerilog package scope
package vlc_pkg;

   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int VLC_CNT_W = 16;
   localparam int VLC_NUM_VEC = 3;
   localparam logic [15:0] VLC_CNT_RST = 16'h0000;
   localparam logic [15:0] VLC_CNT_ONE = 16'h0001;
   localparam logic [15:0] VLC_CNT_TWO = 16'h0002;

   // ----------------------------------------------------------------
   // adder modification select codes
   // ----------------------------------------------------------------
   localparam logic [1:0] VLC_SEL_NONE = 2'h0;
   localparam logic [1:0] VLC_SEL_UNIT = 2'h1;
   localparam logic [1:0] VLC_SEL_INNER = 2'h2;
   localparam logic [1:0] VLC_SEL_OUTER = 2'h3;

   // ----------------------------------------------------------------
   // per-vector controller states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VLC_IDLE,
      VLC_CHECK,
      VLC_RUN
   } vlc_state_t;

endpackage : vlc_pkg

/* File: src/vlc_loop_ctrl.sv */
// vlc_loop_ctrl: shared count holds plus three independent loop controls
// assumes an address generator per vector that pulses addr_done per address
`timescale 1ns/10ps

module vlc_loop_ctrl
   import vlc_pkg::*;
#(
   parameter int CNT_W = VLC_CNT_W,
   parameter int NUM_VEC = VLC_NUM_VEC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // parameter load from the initialization controller
   input wire logic param_load,
   input wire logic [CNT_W-1:0] length_field,
   input wire logic [CNT_W-1:0] inner_count_field,
   input wire logic [CNT_W-1:0] parameter_staging_register,
   // per-vector start and address handshake
   input wire logic [NUM_VEC-1:0] vec_start,
   input wire logic [NUM_VEC-1:0] addr_done,
   // per-vector adder control and status
   output logic [NUM_VEC-1:0] unit_step_en,
   output logic [NUM_VEC-1:0] inner_disp_en,
   output logic [NUM_VEC-1:0] outer_disp_en,
   output logic [NUM_VEC-1:0] gen_active,
   output logic [NUM_VEC-1:0] vec_complete,
   // shared holds visible for status
   output logic [CNT_W-1:0] self_count_hold,
   output logic [CNT_W-1:0] inner_count_hold
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (CNT_W != VLC_CNT_W) begin : g_bad_w
      $error("vlc_loop_ctrl: counter width must be 16");
   end
   if (NUM_VEC < 1) begin : g_bad_n
      $error("vlc_loop_ctrl: need at least one vector");
   end

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rstn_meta_q;
   logic rstn_sync_q;

   // two-stage release of the asynchronous reset
   // only the second stage is read by the rest of the logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstn_meta_q <= 1'b0;
         rstn_sync_q <= 1'b0;
      end else begin
         rstn_meta_q <= 1'b1;
         rstn_sync_q <= rstn_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // shared holding registers
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] self_hold_q;
   logic [CNT_W-1:0] inner_hold_q;

   // holds capture once per operation, used by every vector
   always_ff @(posedge clk or negedge rstn_sync_q) begin
      if (!rstn_sync_q) begin
         self_hold_q <= VLC_CNT_RST;
         inner_hold_q <= VLC_CNT_RST;
      end else if (param_load) begin
         self_hold_q <= length_field;
         inner_hold_q <= inner_count_field;
      end
   end

   assign self_count_hold = self_hold_q;
   assign inner_count_hold = inner_hold_q;

   // ----------------------------------------------------------------
   // per-vector loop control
   // ----------------------------------------------------------------
   // each vector owns its counters and controller; only holds are shared
   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      vlc_state_t state_q;
      logic [CNT_W-1:0] self_cnt_q;
      logic [CNT_W-1:0] inner_cnt_q;
      logic [CNT_W-1:0] outer_cnt_q;
      logic [1:0] sel_q;
      logic [1:0] sel_d;
      logic done_q;
      logic unit_q;
      logic inner_q;
      logic outer_q;
      logic active_q;
      logic start;
      logic self_gt1;
      logic inner_gt1;
      logic outer_gt1;
      logic in_check;
      logic in_run;
      logic check_go;
      logic check_nop;
      logic self_step;
      logic self_last;
      logic disp_take;
      logic inspect;
      logic go_inner;
      logic go_outer;
      logic finish;

      // ----------------------------------------------------------------
      // counter status
      // ----------------------------------------------------------------

      // compare taps the controller watches
      assign self_gt1 = self_cnt_q > VLC_CNT_ONE;
      assign inner_gt1 = inner_cnt_q > VLC_CNT_ONE;
      assign outer_gt1 = outer_cnt_q > VLC_CNT_ONE;

      // ----------------------------------------------------------------
      // controller decisions
      // ----------------------------------------------------------------
      // every decision is a plain decode of flops and inputs

      // a start pulse overrides whatever the vector was doing
      assign start = vec_start[v];
      assign in_check = !start && (state_q == VLC_CHECK);
      assign in_run = !start && (state_q == VLC_RUN);

      // first look at the self count decides if anything is generated
      assign check_go = in_check && self_gt1;
      assign check_nop = in_check && !self_gt1;

      // an address produced under the unit step, and the last of a loop
      assign self_step = in_run && (sel_q == VLC_SEL_UNIT) && addr_done[v];
      assign self_last = self_step && (self_cnt_q == VLC_CNT_TWO);

      // a displacement applied by the adder, stepping resumes after it
      assign disp_take = in_run && addr_done[v] &&
         ((sel_q == VLC_SEL_INNER) || (sel_q == VLC_SEL_OUTER));

      // self loop finished: inner first, then outer, then done
      // an address answer while no select stands is ignored here
      assign inspect = in_run && (sel_q == VLC_SEL_NONE);
      assign go_inner = inspect && inner_gt1;
      assign go_outer = inspect && !inner_gt1 && outer_gt1;
      assign finish = inspect && !inner_gt1 && !outer_gt1;

      // ----------------------------------------------------------------
      // loop counters
      // ----------------------------------------------------------------

      // self counter: load, step per address, reload per new self loop
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            self_cnt_q <= VLC_CNT_RST;
         end else if (start) begin
            self_cnt_q <= self_hold_q;
         end else if (self_step) begin
            self_cnt_q <= self_cnt_q - VLC_CNT_ONE;
         end else if (go_inner || go_outer) begin
            self_cnt_q <= self_hold_q;
         end
      end

      // inner counter: load, step per new self loop, reload per outer
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            inner_cnt_q <= VLC_CNT_RST;
         end else if (start) begin
            inner_cnt_q <= inner_hold_q;
         end else if (go_inner) begin
            inner_cnt_q <= inner_cnt_q - VLC_CNT_ONE;
         end else if (go_outer) begin
            inner_cnt_q <= inner_hold_q;
         end
      end

      // outer counter: straight from staging, step per new inner loop
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            outer_cnt_q <= VLC_CNT_RST;
         end else if (start) begin
            outer_cnt_q <= parameter_staging_register;
         end else if (go_outer) begin
            outer_cnt_q <= outer_cnt_q - VLC_CNT_ONE;
         end
      end

      // ----------------------------------------------------------------
      // controller state and completion
      // ----------------------------------------------------------------

      // idle until started, one look at the counts, then run
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            state_q <= VLC_IDLE;
         end else if (start) begin
            state_q <= VLC_CHECK;
         end else begin
            unique case (state_q)
               VLC_IDLE: begin
                  state_q <= VLC_IDLE;
               end
               VLC_CHECK: begin
                  if (check_go) begin
                     state_q <= VLC_RUN;
                  end else begin
                     state_q <= VLC_IDLE;
                  end
               end
               VLC_RUN: begin
                  if (finish) begin
                     state_q <= VLC_IDLE;
                  end
               end
               default: begin
                  state_q <= VLC_IDLE;
               end
            endcase
         end
      end

      // completion is sticky until the next start of this vector
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            done_q <= 1'b0;
         end else if (start) begin
            done_q <= 1'b0;
         end else if (check_nop || finish) begin
            done_q <= 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // adder select
      // ----------------------------------------------------------------

      // next select; holds unless a decision moves it
      always_comb begin
         sel_d = sel_q;
         if (start || check_nop || self_last || finish) begin
            sel_d = VLC_SEL_NONE;
         end else if (check_go || disp_take) begin
            sel_d = VLC_SEL_UNIT;
         end else if (go_inner) begin
            sel_d = VLC_SEL_INNER;
         end else if (go_outer) begin
            sel_d = VLC_SEL_OUTER;
         end
      end

      // select and its decoded enables all leave from flops
      always_ff @(posedge clk or negedge rstn_sync_q) begin
         if (!rstn_sync_q) begin
            sel_q <= VLC_SEL_NONE;
            unit_q <= 1'b0;
            inner_q <= 1'b0;
            outer_q <= 1'b0;
            active_q <= 1'b0;
         end else begin
            sel_q <= sel_d;
            unit_q <= (sel_d == VLC_SEL_UNIT);
            inner_q <= (sel_d == VLC_SEL_INNER);
            outer_q <= (sel_d == VLC_SEL_OUTER);
            active_q <= (sel_d != VLC_SEL_NONE);
         end
      end

      // ports of this vector
      assign unit_step_en[v] = unit_q;
      assign inner_disp_en[v] = inner_q;
      assign outer_disp_en[v] = outer_q;
      assign gen_active[v] = active_q;
      assign vec_complete[v] = done_q;
   end

endmodule : vlc_loop_ctrl

/* File: tb/vlc_loop_ctrl_checker.sv */
// vlc_loop_ctrl_checker: port assertions for the loop sequencer, vector A
// assumes bind onto vlc_loop_ctrl, raw rstn used as disable
`timescale 1ns/10ps
module vlc_loop_ctrl_checker #(
   parameter int CNT_W = 16,
   parameter int NUM_VEC = 3
) (
   // clock, reset and loads
   input wire logic clk,
   input wire logic rstn,
   input wire logic param_load,
   input wire logic [CNT_W-1:0] length_field,
   input wire logic [CNT_W-1:0] inner_count_field,
   input wire logic [CNT_W-1:0] parameter_staging_register,
   // per-vector handshake and status
   input wire logic [NUM_VEC-1:0] vec_start,
   input wire logic [NUM_VEC-1:0] addr_done,
   input wire logic [NUM_VEC-1:0] unit_step_en,
   input wire logic [NUM_VEC-1:0] inner_disp_en,
   input wire logic [NUM_VEC-1:0] outer_disp_en,
   input wire logic [NUM_VEC-1:0] gen_active,
   input wire logic [NUM_VEC-1:0] vec_complete,
   // shared holds
   input wire logic [CNT_W-1:0] self_count_hold,
   input wire logic [CNT_W-1:0] inner_count_hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // start with a real self-loop, start with nothing to generate
   sequence s_start_long;
      vec_start[0] && self_count_hold > 16'h0001;
   endsequence
   sequence s_start_nop;
      vec_start[0] && self_count_hold <= 16'h0001;
   endsequence
   chk_sel_onehot: assert property (
      $onehot0({unit_step_en[0], inner_disp_en[0], outer_disp_en[0]}))
      else $error("more than one adder select");
   chk_active_decode: assert property (gen_active[0] ==
      (unit_step_en[0] | inner_disp_en[0] | outer_disp_en[0]))
      else $error("gen_active differs from selects");
   chk_done_idle: assert property (vec_complete[0] |-> !gen_active[0])
      else $error("generation active after completion");
   chk_done_sticky: assert property (vec_complete[0] && !vec_start[0]
      |=> vec_complete[0]) else $error("completion dropped");
   chk_start_clear: assert property (vec_start[0]
      |=> !vec_complete[0] && !gen_active[0]) else $error("start not clean");
   chk_start_unit: assert property (s_start_long |=> ##1 unit_step_en[0])
      else $error("unit step not enabled");
   chk_start_nop: assert property (s_start_nop |=> ##1 vec_complete[0])
      else $error("no-op vector not completed");
   chk_inner_resume: assert property (inner_disp_en[0] && addr_done[0]
      |=> unit_step_en[0]) else $error("no unit step after inner");
   chk_outer_resume: assert property (outer_disp_en[0] && addr_done[0]
      |=> unit_step_en[0]) else $error("no unit step after outer");
   chk_self_hold: assert property (param_load
      |=> self_count_hold == $past(length_field)) else $error("self hold");
   chk_inner_hold: assert property (param_load
      |=> inner_count_hold == $past(inner_count_field)) else $error("inner hold");
endmodule : vlc_loop_ctrl_checker

/* File: tb/vlc_agen_model.sv */
// vlc_agen_model: address generator stand-in, one addr_done per address
// assumes gen_active of one vector; slow only holds an answer until tick_q is high, the rate stays one per two cycles
`timescale 1ns/10ps
module vlc_agen_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // select seen, pace, answer
   input wire logic active,
   input wire logic slow,
   output logic addr_done
);
   logic tick_q;
   // pulse then gap; the unit step itself is a fixed one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_q <= 1'b0;
         addr_done <= 1'b0;
      end else begin
         tick_q <= ~tick_q;
         addr_done <= active & ~addr_done & (~slow | tick_q);
      end
   end
endmodule : vlc_agen_model

/* File: tb/testbench.sv */
// testbench: runs loop shapes on all three vectors, counts adder selects
// assumes vlc_pkg, vlc_loop_ctrl, the model and the checker are compiled
`timescale 1ns/10ps
module testbench;
   import vlc_pkg::*;
   logic clk, rstn, param_load;
   logic [15:0] length_field, inner_count_field, parameter_staging_register;
   logic [2:0] vec_start, addr_done, slow, unit_step_en, inner_disp_en;
   logic [2:0] outer_disp_en, gen_active, vec_complete;
   logic [15:0] self_count_hold, inner_count_hold;
   int num_errors = 0, samples_checked = 0, cycles = 0;
   int nu[3], ni[3], no[3];
   vlc_loop_ctrl uut (.clk(clk), .rstn(rstn), .param_load(param_load),
      .length_field(length_field), .inner_count_field(inner_count_field),
      .parameter_staging_register(parameter_staging_register),
      .vec_start(vec_start), .addr_done(addr_done),
      .unit_step_en(unit_step_en), .inner_disp_en(inner_disp_en),
      .outer_disp_en(outer_disp_en), .gen_active(gen_active),
      .vec_complete(vec_complete), .self_count_hold(self_count_hold),
      .inner_count_hold(inner_count_hold));
   for (genvar g = 0; g < 3; g++) begin : g_agen
      vlc_agen_model m (.clk(clk), .rstn(rstn), .active(gen_active[g]),
         .slow(slow[g]), .addr_done(addr_done[g]));
   end
   // clock, select counters and hang limit
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      for (int v = 0; v < 3; v++) begin
         if (addr_done[v] && unit_step_en[v]) nu[v]++;
         if (addr_done[v] && inner_disp_en[v]) ni[v]++;
         if (addr_done[v] && outer_disp_en[v]) no[v]++;
      end
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : compare
   task automatic run_vec(input int s, i, o, input logic [2:0] sl);
      int ns, np, k;
      ns = (i > 1) ? i : 1;
      np = (o > 1) ? o : 1;
      slow = sl;
      length_field = s[15:0];
      inner_count_field = i[15:0];
      param_load = 1'b1;
      @(posedge clk) #1 param_load = 1'b0;
      parameter_staging_register = o[15:0];
      vec_start = 3'h7;
      for (k = 0; k < 3; k++) begin
         nu[k] = 0; ni[k] = 0; no[k] = 0;
      end
      @(posedge clk) #1 vec_start = 3'h0;
      k = 0;
      while (vec_complete !== 3'h7 && k < 3000) begin
         @(posedge clk) #1 k++;
      end
      compare("inner hold", i, inner_count_hold);
      compare("self hold", s, self_count_hold);
      for (k = 0; k < 3; k++) begin
         compare("unit steps", (s > 1) ? (s - 1) * ns * np : 0, nu[k]);
         compare("inner steps", (s > 1) ? (ns - 1) * np : 0, ni[k]);
         compare("outer steps", (s > 1) ? np - 1 : 0, no[k]);
      end
      compare("complete", 3'h7, vec_complete);
      compare("idle", 0, gen_active);
      $display("test S=%0d I=%0d O=%0d finished", s, i, o);
   endtask : run_vec
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // reset, then a table of loop shapes with mixed pacing per vector
   initial begin
      rstn = 1'b0; param_load = 1'b0; vec_start = 3'h0; slow = 3'h0;
      length_field = 16'h0; inner_count_field = 16'h0;
      parameter_staging_register = 16'h0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge clk);
      #1 compare("reset outs", 0, {gen_active, vec_complete});
      $display("test reset finished");
      run_vec(0, 3, 2, 3'h0);
      run_vec(1, 1, 1, 3'h5);
      run_vec(3, 1, 1, 3'h2);
      run_vec(3, 2, 0, 3'h0);
      run_vec(2, 3, 3, 3'h5);
      run_vec(4, 0, 2, 3'h3);
      give_verdict();
   end
endmodule : testbench
bind vlc_loop_ctrl vlc_loop_ctrl_checker #(.CNT_W(CNT_W), .NUM_VEC(NUM_VEC))
   u_chk (.clk(clk), .rstn(rstn), .param_load(param_load),
   .length_field(length_field), .inner_count_field(inner_count_field),
   .parameter_staging_register(parameter_staging_register),
   .vec_start(vec_start), .addr_done(addr_done),
   .unit_step_en(unit_step_en), .inner_disp_en(inner_disp_en),
   .outer_disp_en(outer_disp_en), .gen_active(gen_active),
   .vec_complete(vec_complete), .self_count_hold(self_count_hold),
   .inner_count_hold(inner_count_hold));
